// ### dv/sbcmw_ctrl_properties.sv
// Port-level checks for the mode, wake-up and watchdog controller.
`timescale 1ns/100ps
module sbcmw_ctrl_props #(
	parameter int NREQ_CYC = 600,
	parameter int RESET_DURATION_TIME_CYC = 50,
	parameter int STOP_DELAY_CYC = 20,
	parameter int INT_PULSE_CYC = 10
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic msg_end,
	input wire logic cs_n,
	input wire logic main_regulator_en,
	input wire logic second_regulator_drive,
	input wire logic reset_n,
	input wire logic int_n,
	input wire logic wd_fault_n,
	input wire logic [2:0] mode_state
);
	localparam int SD_LO = STOP_DELAY_CYC;
	localparam int SD_HI = STOP_DELAY_CYC + 3;
	int low_cnt;
	int rst_cnt;
	int nreq_cnt;
	logic wd_seen;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// Lengths of low pulses and of normal-request; repetition cannot reach these counts.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			low_cnt <= 0;
			rst_cnt <= 0;
			nreq_cnt <= 0;
			wd_seen <= 1'b0;
		end else begin
			low_cnt <= int_n ? 0 : low_cnt + 1;
			rst_cnt <= reset_n ? 0 : rst_cnt + 1;
			nreq_cnt <= (mode_state == 3'h1) ? nreq_cnt + 1 : 0;
			wd_seen <= !wd_fault_n || (wd_seen && !(reset_n && rst_cnt != 0));
		end
	end
	chk_normal_regs: assert property ((mode_state == 3'h2) [*3] |-> main_regulator_en && second_regulator_drive)
		else $error("normal mode regulators wrong");
	chk_standby_regs: assert property ((mode_state == 3'h3) [*3] |-> main_regulator_en && !second_regulator_drive)
		else $error("standby regulators wrong");
	chk_sleep_off: assert property ((mode_state == 3'h6) [*3] |-> !main_regulator_en && !second_regulator_drive)
		else $error("sleep regulators not off");
	chk_nreq_regs: assert property ((mode_state == 3'h1) [*3] |-> main_regulator_en && !second_regulator_drive && reset_n)
		else $error("normal-request outputs wrong");
	chk_stop_delay: assert property (mode_state == 3'h4 && msg_end |-> ##[SD_LO:SD_HI] mode_state == 3'h5)
		else $error("stop delay wrong");
	chk_int_width: assert property ($rose(int_n) |-> low_cnt == INT_PULSE_CYC)
		else $error("interrupt pulse width wrong");
	chk_cs_wake: assert property (mode_state == 3'h5 && $rose(cs_n) |-> ##[1:3] mode_state == 3'h1)
		else $error("chip-select wake missing");
	chk_nreq_bound: assert property (nreq_cnt <= NREQ_CYC + 3)
		else $error("normal-request overstayed");
	chk_reset_duration_time: assert property ($rose(reset_n) && wd_seen |-> rst_cnt >= RESET_DURATION_TIME_CYC - 2 && rst_cnt <= RESET_DURATION_TIME_CYC + 2)
		else $error("watchdog reset length wrong");
	chk_fault_resets: assert property (!wd_fault_n |-> ##[0:3] !reset_n)
		else $error("watchdog fault without reset");
	cover property (mode_state == 3'h5);
	cover property ($rose(int_n));
	cover property ($fell(wd_fault_n));
endmodule
bind sbcmw_ctrl sbcmw_ctrl_props #(.NREQ_CYC(NREQ_CYC), .RESET_DURATION_TIME_CYC(RESET_DURATION_TIME_CYC),
	.STOP_DELAY_CYC(STOP_DELAY_CYC), .INT_PULSE_CYC(INT_PULSE_CYC)) u_props (.clk, .resetn,
	.msg_end, .cs_n, .main_regulator_en, .second_regulator_drive, .reset_n, .int_n,
	.wd_fault_n, .mode_state);

// ### dv/sbcmw_ctrl_test.sv
// Self-checking bench for the mode, wake-up and watchdog controller.
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; $display("unexpected at %0t got %h exp %h", $time, a, b); end end
module sbcmw_ctrl_test;
	logic clk, resetn, clk_en, mode_cmd_valid, msg_end, wd_cfg_write, window_select, cfg_on;
	logic period_sel_low, period_sel_high, wd_clear, stop_watchdog_enable, forced_wake_enable;
	logic cyclic_enable, wake_input_zero, wake_input_one, can_wake, cs_n, stop_over_current;
	logic main_regulator_ok, battery_low, status_read, main_regulator_en, main_regulator_full;
	logic second_regulator_drive, high_side_output, reset_n, int_n, wd_fault_n;
	logic battery_fail_flag, over_current_flag;
	logic [1:0] mode_cmd, lpc_ref_bits;
	logic [4:0] wake_input_reg;
	logic [2:0] mode_state;
	int mismatches = 0;
	int samples_checked = 0;
	int n;
	localparam int PER[4] = '{200, 300, 400, 500};
	sbcmw_ctrl #(.NREQ_CYC(600), .RESET_DURATION_TIME_CYC(50), .WD_P0_CYC(200), .WD_P1_CYC(300),
		.WD_P2_CYC(400), .WD_P3_CYC(500), .CYCLIC_CYC(300), .FORCED_CYC(400),
		.STOP_DELAY_CYC(20), .INT_PULSE_CYC(10)) u_dut (.clk, .resetn, .clk_en,
		.mode_cmd_valid, .mode_cmd, .msg_end, .wd_cfg_write, .window_select, .period_sel_low,
		.period_sel_high, .wd_clear, .stop_watchdog_enable, .forced_wake_enable, .cyclic_enable,
		.lpc_ref_bits, .wake_input_zero, .wake_input_one, .can_wake, .cs_n, .stop_over_current,
		.main_regulator_ok, .battery_low, .status_read, .main_regulator_en, .main_regulator_full,
		.second_regulator_drive, .high_side_output, .reset_n, .int_n, .wd_fault_n,
		.battery_fail_flag, .over_current_flag, .wake_input_reg, .mode_state);
	sbcmw_host_model u_host (.clk, .resetn, .cfg_on, .mode_state, .wd_cfg_write,
		.main_regulator_ok);
	// Free-running 100 MHz clock.
	always #5 clk = ~clk;
	task automatic tick(int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask
	task automatic wait_state(logic [2:0] s, int lim);
		n = 0;
		while (mode_state !== s && n < lim) begin
			tick(1);
			n++;
		end
		`CHK(mode_state, s)
	endtask
	task automatic command(logic [1:0] c);
		mode_cmd = c;
		pulse(mode_cmd_valid);
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// The full sequence needs about 5000 cycles; reaching 24000 cycles means a hang.
	initial begin
		#240000;
		mismatches++;
		complete_run();
	end
	// Main sequence: start-up, watchdog, stop, flags, the three sleep wake sources, then wake inputs and clock enable.
	initial begin
		{clk, resetn, mode_cmd_valid, msg_end, cfg_on, period_sel_low, period_sel_high} = '0;
		{wd_clear, stop_watchdog_enable, forced_wake_enable, cyclic_enable, can_wake} = '0;
		{wake_input_zero, wake_input_one, stop_over_current, battery_low, status_read} = '0;
		{clk_en, window_select, cs_n, mode_cmd, lpc_ref_bits} = 7'h7F;
		tick(12);
		resetn = 1'b1;
		wait_state(3'h1, 20);
		`CHK({reset_n, second_regulator_drive}, 2'h2)
		wait_state(3'h0, 700);
		cfg_on = 1'b1;
		wait_state(3'h2, 800);
		tick(150);
		pulse(wd_clear);
		tick(150);
		pulse(wd_clear);
		`CHK(mode_state, 3'h2)
		tick(30);
		pulse(wd_clear);
		wait_state(3'h0, 5);
		$display("test window watchdog done");
		window_select = 1'b0;
		for (int i = 0; i < 4; i++) begin
			{period_sel_high, period_sel_low} = 2'(i);
			wait_state(3'h2, 800);
			wait_state(3'h0, 600);
			`CHK(n >= PER[i] - 3 && n <= PER[i] + 3, 1'b1)
		end
		$display("test periods done");
		wait_state(3'h2, 800);
		command(2'h1);
		tick(3);
		`CHK({mode_state, main_regulator_en, second_regulator_drive}, 5'h0E)
		command(2'h3);
		tick(2);
		pulse(msg_end);
		wait_state(3'h5, 30);
		`CHK(n >= 18, 1'b1)
		`CHK({main_regulator_full, second_regulator_drive}, 2'h0)
		cs_n = 1'b0;
		tick(1);
		cs_n = 1'b1;
		wait_state(3'h1, 5);
		n = 0;
		while (int_n !== 1'b0 && n < 10) begin
			tick(1);
			n++;
		end
		`CHK({int_n, wake_input_reg[4]}, 2'h1)
		wait_state(3'h2, 100);
		command(2'h3);
		pulse(msg_end);
		wait_state(3'h5, 30);
		stop_over_current = 1'b1;
		wait_state(3'h1, 5);
		stop_over_current = 1'b0;
		`CHK(over_current_flag, 1'b1)
		pulse(status_read);
		`CHK(over_current_flag, 1'b0)
		wait_state(3'h2, 100);
		stop_watchdog_enable = 1'b1;
		command(2'h3);
		pulse(msg_end);
		wait_state(3'h5, 30);
		wait_state(3'h0, 600);
		`CHK(reset_n, 1'b0)
		stop_watchdog_enable = 1'b0;
		battery_low = 1'b1;
		tick(2);
		battery_low = 1'b0;
		`CHK(battery_fail_flag, 1'b1)
		pulse(status_read);
		`CHK(battery_fail_flag, 1'b0)
		$display("test stop and flags done");
		for (int k = 0; k < 3; k++) begin
			forced_wake_enable = (k != 0);
			cyclic_enable = (k == 2);
			wait_state(3'h2, 800);
			lpc_ref_bits = 2'h0;
			tick(1);
			lpc_ref_bits = 2'h3;
			pulse(status_read);
			command(2'h2);
			wait_state(3'h6, 5);
			can_wake = (k == 0);
			if (k == 2) begin
				wait (high_side_output === 1'b1 || n > 9);
				tick(150);
				`CHK(mode_state, 3'h6)
				cs_n = 1'b0;
				tick(1);
				cs_n = 1'b1;
			end
			wait_state(3'h0, 500);
			can_wake = 1'b0;
			wait_state(3'h1, 20);
			`CHK(wake_input_reg[2 + k], 1'b1)
		end
		// Plain wake inputs with no cyclic sense: a level change against the reference wakes.
		forced_wake_enable = 1'b0;
		cyclic_enable = 1'b0;
		wait_state(3'h2, 800);
		lpc_ref_bits = 2'h0;
		tick(1);
		lpc_ref_bits = 2'h3;
		pulse(status_read);
		command(2'h2);
		wait_state(3'h6, 5);
		{wake_input_one, wake_input_zero} = 2'h3;
		wait_state(3'h0, 10);
		wait_state(3'h1, 20);
		`CHK(wake_input_reg[1:0], 2'h3)
		{wake_input_one, wake_input_zero} = 2'h0;
		// A low clock enable freezes the watchdog, so normal mode survives a long pause.
		wait_state(3'h2, 800);
		clk_en = 1'b0;
		tick(600);
		`CHK({mode_state, reset_n}, 4'h5)
		clk_en = 1'b1;
		$display("test wake inputs and clock enable done");
		$display("test sleep wake done");
		complete_run();
	end
endmodule

// ### dv/sbcmw_host_model.sv
// Host and main rail model: rail level and the watchdog setup write.
`timescale 1ns/100ps
module sbcmw_host_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic cfg_on,
	input wire logic [2:0] mode_state,
	output logic wd_cfg_write,
	output logic main_regulator_ok
);
	int wait_cnt;
	// The rail collapses in sleep and is in range again once reset mode is under way.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) main_regulator_ok <= 1'b0;
		else if (mode_state == 3'h6) main_regulator_ok <= 1'b0;
		else if (mode_state == 3'h0) main_regulator_ok <= 1'b1;
	end
	// A prompt host writes once, 20 cycles into normal-request; a silent one lets it expire.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wait_cnt <= 0;
			wd_cfg_write <= 1'b0;
		end else begin
			wait_cnt <= (mode_state == 3'h1) ? wait_cnt + 1 : 0;
			wd_cfg_write <= cfg_on && wait_cnt == 20;
		end
	end
endmodule

// ### rtl/sbcmw_ctrl.sv
// Operating-mode state machine with watchdog, wake-up and reset/interrupt generation.
// Behaviour
// - Normal, standby, sleep, stop by command; normal-request entered after wake-ups.
// - Normal: both regulators on, all functions, watchdog runs and needs clearing.
// - Standby: main regulator only, second drive off, watchdog still runs.
// - Sleep: both regulators off; wake on cyclic sense, forced, CAN, chip-select.
// - Stop becomes active 20 us after the command message ends.
// - In stop the watchdog runs only if its enable bit is set.
// - Stop watchdog expiry asserts reset then enters normal-request.
// - Device-side stop wake: normal-request, full regulator, then 10 us interrupt low.
// - Chip-select rising edge in sleep or stop wakes; only the stop wake pulses interrupt.
// - Stop over-current wakes to normal-request, unmaskable interrupt, sets flag.
// - Normal-request: main on, second off, 350 ms timer until watchdog configured.
// - Battery-fail flag set on low supply, cleared on its register read.
// - Reset low while main regulator below threshold, also at power-on and sleep wake.
// - Watchdog timeout drives reset low for the reset duration.
// - Watchdog in normal and standby; window or timeout, window default.
// - Two bits select the watchdog period from 5 to 350 ms.
// - Window mode: clear in closed first half causes reset except in stop, where it only restarts the count; open half clears.
// - Wake sources latched into readable status; options set before low power.
// - Cyclic sense pulses high-side output; cyclic and forced wake exclusive.
// - Wake input references sampled on config bits set and each cyclic event.
// - Forced wake after a set time when enabled; CAN wake always enabled.
// - Power-up or sleep wake passes reset mode then normal-request.
`timescale 1ns/100ps
`include "sbcmw_cfg.svh"
module sbcmw_ctrl #(
	parameter int NREQ_CYC = `SBCMW_NREQ_CYC,
	parameter int RESET_DURATION_TIME_CYC = `SBCMW_RESET_DURATION_TIME_CYC,
	parameter int WD_P0_CYC = `SBCMW_WD_P0_CYC,
	parameter int WD_P1_CYC = `SBCMW_WD_P1_CYC,
	parameter int WD_P2_CYC = `SBCMW_WD_P2_CYC,
	parameter int WD_P3_CYC = `SBCMW_WD_P3_CYC,
	parameter int CYCLIC_CYC = `SBCMW_CYCLIC_CYC,
	parameter int FORCED_CYC = `SBCMW_FORCED_CYC,
	parameter int STOP_DELAY_CYC = `SBCMW_STOP_DELAY_CYC,
	parameter int INT_PULSE_CYC = `SBCMW_INT_PULSE_CYC
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic mode_cmd_valid,
	input wire logic [1:0] mode_cmd,
	input wire logic msg_end,
	input wire logic wd_cfg_write,
	input wire logic window_select,
	input wire logic period_sel_low,
	input wire logic period_sel_high,
	input wire logic wd_clear,
	input wire logic stop_watchdog_enable,
	input wire logic forced_wake_enable,
	input wire logic cyclic_enable,
	input wire logic [1:0] lpc_ref_bits,
	input wire logic wake_input_zero,
	input wire logic wake_input_one,
	input wire logic can_wake,
	input wire logic cs_n,
	input wire logic stop_over_current,
	input wire logic main_regulator_ok,
	input wire logic battery_low,
	input wire logic status_read,
	output logic main_regulator_en,
	output logic main_regulator_full,
	output logic second_regulator_drive,
	output logic high_side_output,
	output logic reset_n,
	output logic int_n,
	output logic wd_fault_n,
	output logic battery_fail_flag,
	output logic over_current_flag,
	output logic [4:0] wake_input_reg,
	output logic [2:0] mode_state
);
	sbcmw_pkg::sbcmw_state_t state;
	logic [31:0] timer;
	logic [31:0] wd_cnt;
	logic [31:0] rst_cnt;
	logic [31:0] lp_cnt;
	logic [31:0] int_cnt;
	logic [31:0] wd_period;
	logic wd_window;
	logic [1:0] wd_per;
	logic cs_prev;
	logic cs_rise;
	logic [1:0] ref_lvl;
	logic [1:0] lpc_prev;
	logic lp;
	logic wd_run;
	logic wd_expire;
	logic wd_bad_clear;
	logic wd_trip;
	logic cyc_evt;
	logic forced_evt;
	logic input_chg;
	logic dev_wake;
	logic int_pend;
	logic cyc_en;
	logic fwu_en;

	// Cyclic sense wins when both enables are set, keeping the two exclusive.
	assign cyc_en = cyclic_enable;
	assign fwu_en = forced_wake_enable & ~cyclic_enable;
	assign lp = (state == sbcmw_pkg::SBCMW_SLEEP) || (state == sbcmw_pkg::SBCMW_STOP);
	assign cs_rise = cs_n & ~cs_prev;
	assign cyc_evt = lp && cyc_en && (lp_cnt == 32'(CYCLIC_CYC - 1));
	assign forced_evt = lp && fwu_en && (lp_cnt == 32'(FORCED_CYC - 1));
	assign input_chg = cyc_en ? (high_side_output &&
		({wake_input_one, wake_input_zero} != ref_lvl))
		: ({wake_input_one, wake_input_zero} != ref_lvl);
	assign dev_wake = lp && (can_wake || forced_evt || input_chg);

	// Watchdog period from the two select bits.
	always_comb begin
		case (wd_per)
			2'h0: wd_period = 32'(WD_P0_CYC);
			2'h1: wd_period = 32'(WD_P1_CYC);
			2'h2: wd_period = 32'(WD_P2_CYC);
			default: wd_period = 32'(WD_P3_CYC);
		endcase
	end

	// Watchdog runs in normal, standby and stop-wait, and in stop only when enabled.
	assign wd_run = (state == sbcmw_pkg::SBCMW_NORMAL) || (state == sbcmw_pkg::SBCMW_STANDBY)
		|| (state == sbcmw_pkg::SBCMW_STOP_WAIT)
		|| ((state == sbcmw_pkg::SBCMW_STOP) && stop_watchdog_enable);
	assign wd_expire = wd_run && (wd_cnt >= wd_period - 32'h1);
	assign wd_bad_clear = wd_run && wd_clear && wd_window
		&& (wd_cnt < (wd_period >> 1));
	assign wd_trip = wd_expire || wd_bad_clear;

	// Watchdog configuration is latched only from the configuration write.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wd_window <= `SBCMW_WINDOW_RST;
			wd_per <= 2'h0;
		end else if (clk_en && wd_cfg_write) begin
			wd_window <= window_select;
			wd_per <= {period_sel_high, period_sel_low};
		end
	end

	// Watchdog counter; a legal clear restarts the period.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wd_cnt <= 32'h0;
		end else if (clk_en) begin
			if (!wd_run || wd_trip || (wd_clear && !wd_bad_clear)) begin
				wd_cnt <= 32'h0;
			end else begin
				wd_cnt <= wd_cnt + 32'h1;
			end
		end
	end

	// Main mode state machine.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= sbcmw_pkg::SBCMW_RESET;
			timer <= 32'h0;
			rst_cnt <= 32'h0;
		end else if (clk_en) begin
			case (state)
				sbcmw_pkg::SBCMW_RESET: begin
					// Hold here for the watchdog reset time and until the supply is good.
					if (rst_cnt != 32'h0) begin
						rst_cnt <= rst_cnt - 32'h1;
					end else if (main_regulator_ok) begin
						state <= sbcmw_pkg::SBCMW_NREQ;
						timer <= 32'h0;
					end
				end
				sbcmw_pkg::SBCMW_NREQ: begin
					timer <= timer + 32'h1;
					if (wd_cfg_write) begin
						state <= sbcmw_pkg::SBCMW_NORMAL;
					end else if (timer >= 32'(NREQ_CYC - 1)) begin
						state <= sbcmw_pkg::SBCMW_RESET;
						rst_cnt <= 32'(RESET_DURATION_TIME_CYC - 1);
					end
				end
				sbcmw_pkg::SBCMW_NORMAL, sbcmw_pkg::SBCMW_STANDBY: begin
					if (wd_trip) begin
						state <= sbcmw_pkg::SBCMW_RESET;
						rst_cnt <= 32'(RESET_DURATION_TIME_CYC - 1);
					end else if (mode_cmd_valid) begin
						case (sbcmw_pkg::sbcmw_cmd_t'(mode_cmd))
							sbcmw_pkg::SBCMW_CMD_NORMAL: state <= sbcmw_pkg::SBCMW_NORMAL;
							sbcmw_pkg::SBCMW_CMD_STANDBY: state <= sbcmw_pkg::SBCMW_STANDBY;
							sbcmw_pkg::SBCMW_CMD_SLEEP: state <= sbcmw_pkg::SBCMW_SLEEP;
							default: state <= sbcmw_pkg::SBCMW_STOP_WAIT;
						endcase
						timer <= 32'h0;
					end
				end
				sbcmw_pkg::SBCMW_STOP_WAIT: begin
					// The 20 us count starts at the end of the command message.
					if (wd_trip) begin
						state <= sbcmw_pkg::SBCMW_RESET;
						rst_cnt <= 32'(RESET_DURATION_TIME_CYC - 1);
					end else if (timer != 32'h0) begin
						timer <= timer + 32'h1;
						if (timer >= 32'(STOP_DELAY_CYC)) begin
							state <= sbcmw_pkg::SBCMW_STOP;
						end
					end else if (msg_end) begin
						timer <= 32'h1;
					end
				end
				sbcmw_pkg::SBCMW_STOP: begin
					if (wd_expire) begin
						state <= sbcmw_pkg::SBCMW_RESET;
						rst_cnt <= 32'(RESET_DURATION_TIME_CYC - 1);
					end else if (dev_wake || cs_rise || stop_over_current) begin
						state <= sbcmw_pkg::SBCMW_NREQ;
						timer <= 32'h0;
					end
				end
				sbcmw_pkg::SBCMW_SLEEP: begin
					if (dev_wake || cs_rise) begin
						state <= sbcmw_pkg::SBCMW_RESET;
					end
				end
				default: state <= sbcmw_pkg::SBCMW_RESET;
			endcase
			// A supply dip overrides every mode where the main regulator is on, except stop.
			if (!main_regulator_ok && main_regulator_en && state != sbcmw_pkg::SBCMW_STOP) begin
				state <= sbcmw_pkg::SBCMW_RESET;
			end
		end
	end

	// Low-power time base for cyclic sense and forced wake.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lp_cnt <= 32'h0;
			high_side_output <= 1'b0;
		end else if (clk_en) begin
			if (!lp || cyc_evt || forced_evt) begin
				lp_cnt <= 32'h0;
			end else begin
				lp_cnt <= lp_cnt + 32'h1;
			end
			// The high-side switch biases the wake inputs for a short window.
			high_side_output <= lp && cyc_en && (lp_cnt < 32'(`SBCMW_HS_ON_CYC));
		end
	end

	// Wake input reference levels, tracked outside low power and taken on a rising config bit or at each sense.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ref_lvl <= 2'h0;
			lpc_prev <= 2'h0;
			cs_prev <= 1'b1;
		end else if (clk_en) begin
			lpc_prev <= lpc_ref_bits;
			cs_prev <= cs_n;
			if ((lpc_ref_bits == 2'h3 && lpc_prev != 2'h3) || cyc_evt || !lp) begin
				ref_lvl <= {wake_input_one, wake_input_zero};
			end
		end
	end

	// Wake source latches; a new source wins over a read in the same cycle.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wake_input_reg <= 5'h00;
		end else if (clk_en) begin
			wake_input_reg <= (status_read ? 5'h00 : wake_input_reg) | {
				lp && cs_rise,
				forced_evt,
				lp && can_wake,
				lp && input_chg && (wake_input_one != ref_lvl[1]),
				lp && input_chg && (wake_input_zero != ref_lvl[0])};
		end
	end

	// Battery-fail and over-current flags, set beats clear.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			battery_fail_flag <= 1'b0;
			over_current_flag <= 1'b0;
		end else if (clk_en) begin
			battery_fail_flag <= battery_low || (battery_fail_flag && !status_read);
			over_current_flag <= (state == sbcmw_pkg::SBCMW_STOP && stop_over_current)
				|| (over_current_flag && !status_read);
		end
	end

	// Interrupt pulse waits for the full regulator, then goes low for 10 us.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			int_pend <= 1'b0;
			int_cnt <= 32'h0;
			int_n <= 1'b1;
		end else if (clk_en) begin
			if (state == sbcmw_pkg::SBCMW_STOP && !wd_expire
				&& (dev_wake || cs_rise || stop_over_current)) begin
				int_pend <= 1'b1;
			end else if (int_pend && main_regulator_ok && state == sbcmw_pkg::SBCMW_NREQ) begin
				int_pend <= 1'b0;
				int_cnt <= 32'(INT_PULSE_CYC);
			end else if (int_cnt != 32'h0) begin
				int_cnt <= int_cnt - 32'h1;
			end
			int_n <= ~(int_cnt != 32'h0);
		end
	end

	// Regulator, reset and status outputs registered from the state.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			main_regulator_en <= 1'b0;
			main_regulator_full <= 1'b0;
			second_regulator_drive <= 1'b0;
			reset_n <= 1'b0;
			wd_fault_n <= 1'b1;
			mode_state <= 3'h0;
		end else if (clk_en) begin
			main_regulator_en <= (state != sbcmw_pkg::SBCMW_SLEEP);
			main_regulator_full <= (state != sbcmw_pkg::SBCMW_SLEEP)
				&& (state != sbcmw_pkg::SBCMW_STOP);
			second_regulator_drive <= (state == sbcmw_pkg::SBCMW_NORMAL);
			reset_n <= (state != sbcmw_pkg::SBCMW_RESET) && main_regulator_ok;
			wd_fault_n <= ~(wd_trip || (state == sbcmw_pkg::SBCMW_NREQ
				&& timer >= 32'(NREQ_CYC - 1) && !wd_cfg_write));
			mode_state <= state;
		end
	end
endmodule

// ### shared/sbcmw_cfg.svh
// Timing constants and reset values for the mode, wake-up and watchdog controller.
`ifndef SBCMW_CFG_SVH
`define SBCMW_CFG_SVH
`define SBCMW_CLK_MHZ 100
`define SBCMW_STOP_DELAY_US 20
`define SBCMW_STOP_DELAY_CYC (`SBCMW_STOP_DELAY_US * `SBCMW_CLK_MHZ)
`define SBCMW_INT_PULSE_US 10
`define SBCMW_INT_PULSE_CYC (`SBCMW_INT_PULSE_US * `SBCMW_CLK_MHZ)
`define SBCMW_NREQ_MS 350
`define SBCMW_NREQ_CYC (`SBCMW_NREQ_MS * 1000 * `SBCMW_CLK_MHZ)
`define SBCMW_RESET_DURATION_TIME_US 1000
`define SBCMW_RESET_DURATION_TIME_CYC (`SBCMW_RESET_DURATION_TIME_US * `SBCMW_CLK_MHZ)
`define SBCMW_WD_P0_US 5000
`define SBCMW_WD_P1_US 45000
`define SBCMW_WD_P2_US 100000
`define SBCMW_WD_P3_US 350000
`define SBCMW_WD_P0_CYC (`SBCMW_WD_P0_US * `SBCMW_CLK_MHZ)
`define SBCMW_WD_P1_CYC (`SBCMW_WD_P1_US * `SBCMW_CLK_MHZ)
`define SBCMW_WD_P2_CYC (`SBCMW_WD_P2_US * `SBCMW_CLK_MHZ)
`define SBCMW_WD_P3_CYC (`SBCMW_WD_P3_US * `SBCMW_CLK_MHZ)
`define SBCMW_CYCLIC_US 20000
`define SBCMW_CYCLIC_CYC (`SBCMW_CYCLIC_US * `SBCMW_CLK_MHZ)
`define SBCMW_FORCED_US 50000
`define SBCMW_FORCED_CYC (`SBCMW_FORCED_US * `SBCMW_CLK_MHZ)
`define SBCMW_HS_ON_CYC 100
`define SBCMW_WINDOW_RST 1'b1
`endif

// ### shared/sbcmw_pkg.sv
// Types shared by the mode, wake-up and watchdog controller.
package sbcmw_pkg;
	typedef enum logic [1:0] {
		SBCMW_CMD_NORMAL,
		SBCMW_CMD_STANDBY,
		SBCMW_CMD_SLEEP,
		SBCMW_CMD_STOP
	} sbcmw_cmd_t;
	typedef enum logic [2:0] {
		SBCMW_RESET,
		SBCMW_NREQ,
		SBCMW_NORMAL,
		SBCMW_STANDBY,
		SBCMW_STOP_WAIT,
		SBCMW_STOP,
		SBCMW_SLEEP
	} sbcmw_state_t;
endpackage
